// ===== design/wdt_pkg.sv
// Constants for the port-mapped watchdog timer.
package wdt_pkg;
    // Port addresses decoded on the host I/O bus.
    localparam logic [11:0] PERIOD_PORT = 12'h443;
    localparam logic [11:0] STOP_PORT_LO = 12'h043;
    localparam logic [11:0] STOP_PORT_HI = 12'h843;
    // Time base.
    localparam int CLK_HZ = 100000000;
    localparam int TICK_S = 1;
    localparam int TICK_CYCLES = CLK_HZ * TICK_S;
    // Period reset value, board reset pulse width and control read data.
    localparam logic [7:0] PERIOD_RST = 8'h01;
    localparam int RESET_PULSE_CYCLES = 16;
    localparam logic [7:0] READ_DATA = 8'hFF;
endpackage : wdt_pkg

// ===== design/io_port_watchdog_timer.sv
// Watchdog timer driven by host I/O port reads and writes.
`timescale 1ns/1ps
module io_port_watchdog_timer #(
    parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES,
    parameter int PULSE_CYCLES = wdt_pkg::RESET_PULSE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [11:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic board_reset,
    output logic running
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_FIRE = 2'b10
    } wdt_state_e;

    wdt_state_e state_ff;
    logic [7:0] period_ff;
    logic [7:0] count_ff;
    logic [31:0] tick_cnt_ff;
    logic [31:0] pulse_cnt_ff;
    logic tick;
    logic kick;
    logic stop;
    logic expire;

    assign kick = io_rd && (io_addr == wdt_pkg::PERIOD_PORT);
    assign stop = io_rd && (io_addr == wdt_pkg::STOP_PORT_LO
        || io_addr == wdt_pkg::STOP_PORT_HI);
    assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));
    assign expire = tick && (count_ff == 8'h01);

    ////////////////////////////////////////////////////////////////////////////
    // period store
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            period_ff <= wdt_pkg::PERIOD_RST;
        else if (clk_en && io_wr && io_addr == wdt_pkg::PERIOD_PORT)
            period_ff <= io_wdata;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            tick_cnt_ff <= 32'h0;
        else if (clk_en)
        begin
            if (kick || state_ff != ST_RUN || tick)
                tick_cnt_ff <= 32'h0;
            else
                tick_cnt_ff <= tick_cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_ff <= ST_IDLE;
            count_ff <= 8'h00;
        end
        else if (clk_en)
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (kick && !stop)
                    begin
                        state_ff <= ST_RUN;
                        count_ff <= period_ff;
                    end
                end
                ST_RUN:
                begin
                    if (stop)
                        state_ff <= ST_IDLE;
                    else if (kick)
                        count_ff <= period_ff;
                    else if (expire || count_ff == 8'h00)
                    begin
                        state_ff <= ST_FIRE;
                        count_ff <= 8'h00;
                    end
                    else if (tick)
                        count_ff <= count_ff - 8'h01;
                end
                ST_FIRE:
                begin
                    if (pulse_cnt_ff == 32'(PULSE_CYCLES - 1))
                        state_ff <= ST_IDLE;
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            pulse_cnt_ff <= 32'h0;
        else if (clk_en)
        begin
            if (state_ff == ST_FIRE)
                pulse_cnt_ff <= pulse_cnt_ff + 32'h1;
            else
                pulse_cnt_ff <= 32'h0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            board_reset <= 1'b0;
            running <= 1'b0;
            io_rdata <= 8'h00;
        end
        else if (clk_en)
        begin
            board_reset <= (state_ff == ST_RUN && !stop && !kick
                && (expire || count_ff == 8'h00))
                || (state_ff == ST_FIRE && pulse_cnt_ff != 32'(PULSE_CYCLES - 1));
            running <= (state_ff == ST_RUN && !stop
                && (kick || !(expire || count_ff == 8'h00)))
                || (state_ff == ST_IDLE && kick && !stop);
            io_rdata <= (kick || stop) ? wdt_pkg::READ_DATA : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_STOP_HALTS: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && stop && state_ff != ST_FIRE |=> !running && state_ff == ST_IDLE)
        else $error("Stop read did not halt the timer.");
    AST_KICK_LOADS: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && kick && !stop && state_ff != ST_FIRE
        |=> count_ff == $past(period_ff) && running)
        else $error("Kick read did not load the period.");
    AST_WRITE_NO_ARM: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && io_wr && !io_rd && state_ff == ST_IDLE |=> state_ff == ST_IDLE)
        else $error("Period write armed the timer.");
    AST_WRITE_STORES: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && io_wr && io_addr == wdt_pkg::PERIOD_PORT |=> period_ff == $past(io_wdata))
        else $error("Period write not stored.");
    AST_EXPIRE_FIRES: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && state_ff == ST_RUN && expire && !kick && !stop |=> board_reset)
        else $error("Expiry did not reset the board.");
    AST_IDLE_QUIET: assert property (@(posedge ref_clk) disable iff (srst)
        state_ff == ST_IDLE && $past(state_ff) == ST_IDLE |-> !board_reset)
        else $error("Reset driven while stopped.");
    AST_TICK_DEC: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && state_ff == ST_RUN && tick && !kick && !stop && count_ff > 8'h01
        |=> count_ff == $past(count_ff) - 8'h01)
        else $error("Tick did not decrement count.");
    AST_FIRE_ENDS: assert property (@(posedge ref_clk) disable iff (srst)
        state_ff == ST_FIRE && clk_en && pulse_cnt_ff == 32'(PULSE_CYCLES - 1)
        |=> state_ff == ST_IDLE && count_ff == 8'h00)
        else $error("Fire state did not return to stopped.");

    ////////////////////////////////////////////////////////////////////////////
    AST_RESET_IS_FIRE: assert property (@(posedge ref_clk) disable iff (srst)
        board_reset == (state_ff == ST_FIRE))
        else $error("Board reset out of step with the fire state.");
    AST_FIRE_HOLDS: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && state_ff == ST_FIRE && pulse_cnt_ff != 32'(PULSE_CYCLES - 1)
        |=> state_ff == ST_FIRE && board_reset)
        else $error("Reset pulse cut short.");
    AST_PULSE_BOUND: assert property (@(posedge ref_clk) disable iff (srst)
        state_ff == ST_FIRE
        |-> pulse_cnt_ff < 32'(PULSE_CYCLES))
        else $error("Reset pulse counter ran past its width.");
    AST_RUN_IS_STATE: assert property (@(posedge ref_clk) disable iff (srst)
        running == (state_ff == ST_RUN))
        else $error("Running flag out of step with the run state.");
    AST_TICK_RESTART: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && kick && !stop && state_ff != ST_FIRE
        |=> tick_cnt_ff == 32'h0)
        else $error("Kick did not restart the second counter.");
    AST_RDATA_ANSWER: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && (kick || stop)
        |=> io_rdata == wdt_pkg::READ_DATA)
        else $error("Control read gave wrong data.");
    AST_RDATA_QUIET: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && !kick && !stop
        |=> io_rdata == 8'h00)
        else $error("Read data not cleared.");
    AST_STOP_NO_FIRE: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && stop && state_ff != ST_FIRE
        |=> !board_reset)
        else $error("Reset driven after a stop read.");
    AST_IDLE_TICK_CLEAR: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && state_ff != ST_RUN
        |=> tick_cnt_ff == 32'h0)
        else $error("Second counter ran while not armed.");
    AST_FROZEN: assert property (@(posedge ref_clk) disable iff (srst)
        !clk_en
        |=> state_ff == $past(state_ff) && count_ff == $past(count_ff)
            && tick_cnt_ff == $past(tick_cnt_ff) && board_reset == $past(board_reset))
        else $error("State moved while the clock enable was low.");
    AST_PERIOD_HOLDS: assert property (@(posedge ref_clk) disable iff (srst)
        !(clk_en && io_wr && io_addr == wdt_pkg::PERIOD_PORT)
        |=> period_ff == $past(period_ff))
        else $error("Period changed without a write.");
endmodule : io_port_watchdog_timer

// ===== bench/host_io.sv
// Host processor model issuing I/O port reads and writes.
`timescale 1ns/1ps
module host_io (
    input wire logic ref_clk,
    output logic [11:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata
);
    initial
    begin
        io_addr = 12'h000;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end
    task acc(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        io_addr = a;
        io_wdata = d;
        io_wr = w;
        io_rd = !w;
        @(negedge ref_clk);
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = ~a;
        io_wdata = ~d;
    endtask : acc
endmodule : host_io

// ===== bench/tb.sv
// Self-checking testbench of the port watchdog.
`timescale 1ns/1ps
module tb;
    localparam int TK = 10;
    localparam int PW = 4;
    localparam logic [11:0] PP = wdt_pkg::PERIOD_PORT;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    logic [11:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic board_reset;
    logic running;
    int error_cnt = 0;
    int comparisons = 0;
    int n;
    logic [7:0] pv [2] = '{8'hFF, 8'h01};
    logic [11:0] sp [2] = '{wdt_pkg::STOP_PORT_LO, wdt_pkg::STOP_PORT_HI};
    always #5 ref_clk = ~ref_clk;
    host_io host_io_inst (.ref_clk(ref_clk), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata));
    io_port_watchdog_timer #(.TICK_CYCLES(TK), .PULSE_CYCLES(PW)) io_port_watchdog_timer_inst (
        .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .board_reset(board_reset),
        .running(running));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task end_sim;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim
    task expire(input int cyc);
        n = 0;
        while (board_reset !== 1'b1 && n < 3000)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk(8'(n >= cyc && n <= cyc + 1), 8'h01);
        if (n >= 3000)
            end_sim();
        chk({7'h00, running}, 8'h00);
        n = 0;
        while (board_reset === 1'b1 && n < 100)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk(8'(n), 8'(PW));
    endtask : expire
    task quiet(input int cyc);
        n = 0;
        repeat (cyc)
        begin
            @(negedge ref_clk);
            n += int'(board_reset !== 1'b0);
        end
        chk(8'(n), 8'h00);
    endtask : quiet
    initial
    begin
        repeat (6) @(negedge ref_clk);
        srst = 1'b0;
        chk({6'h00, board_reset, running}, 8'h00);
        host_io_inst.acc(1'b1, PP, 8'h03);
        host_io_inst.acc(1'b1, 12'h444, 8'h01);
        chk({7'h00, running}, 8'h00);
        host_io_inst.acc(1'b0, 12'h444, 8'h00);
        chk(io_rdata, 8'h00);
        host_io_inst.acc(1'b0, PP, 8'h00);
        chk(io_rdata, wdt_pkg::READ_DATA);
        chk({7'h00, running}, 8'h01);
        repeat (2 * TK) @(negedge ref_clk);
        host_io_inst.acc(1'b0, PP, 8'h00);
        expire(3 * TK);
        chk({6'h00, board_reset, running}, 8'h00);
        host_io_inst.acc(1'b1, PP, 8'h02);
        host_io_inst.acc(1'b0, PP, 8'h00);
        repeat (5) @(negedge ref_clk);
        clk_en = 1'b0;
        quiet(4 * TK);
        chk({7'h00, running}, 8'h01);
        clk_en = 1'b1;
        expire(2 * TK - 5);
        for (int i = 0; i < 2; i++)
        begin
            host_io_inst.acc(1'b1, PP, pv[i]);
            host_io_inst.acc(1'b0, PP, 8'h00);
            expire(int'(pv[i]) * TK);
        end
        host_io_inst.acc(1'b0, PP, 8'h00);
        expire(TK);
        host_io_inst.acc(1'b1, PP, 8'h00);
        host_io_inst.acc(1'b0, PP, 8'h00);
        expire(1);
        host_io_inst.acc(1'b1, PP, 8'h03);
        host_io_inst.acc(1'b0, PP, 8'h00);
        repeat (5) @(negedge ref_clk);
        srst = 1'b1;
        repeat (2) @(negedge ref_clk);
        srst = 1'b0;
        chk({6'h00, board_reset, running}, 8'h00);
        quiet(4 * TK);
        host_io_inst.acc(1'b0, PP, 8'h00);
        expire(int'(wdt_pkg::PERIOD_RST) * TK);
        host_io_inst.acc(1'b1, PP, 8'h03);
        for (int i = 0; i < 2; i++)
        begin
            host_io_inst.acc(1'b0, PP, 8'h00);
            host_io_inst.acc(1'b0, sp[i], 8'h00);
            chk({io_rdata[0], running}, 2'b10);
            quiet(5 * TK);
        end
        end_sim();
    end
endmodule : tb
